// File: ach_pkg.sv
// constants for the aperture configuration header slice
// assumes configuration offsets are byte offsets and accesses are dword wide with byte enables
package ach_pkg;
  // dword-aligned configuration offsets
  localparam logic [7:0] ACH_CLASS_DW_OFS = 8'h08;
  localparam logic [7:0] ACH_TIMER_DW_OFS = 8'h0C;
  localparam logic [7:0] ACH_BASE_DW_OFS = 8'h10;
  // byte offsets of the single-byte registers
  localparam logic [7:0] ACH_SUBCAT_OFS = 8'h0A;
  localparam logic [7:0] ACH_CATEGORY_OFS = 8'h0B;
  localparam logic [7:0] ACH_LATENCY_OFS = 8'h0D;
  localparam logic [7:0] ACH_LAYOUT_OFS = 8'h0E;
  // constant byte values
  localparam logic [7:0] ACH_SUBCAT_VAL = 8'h00;
  localparam logic [7:0] ACH_CATEGORY_VAL = 8'h06;
  localparam logic [7:0] ACH_LATENCY_VAL = 8'h00;
  localparam logic [7:0] ACH_LAYOUT_VAL = 8'h00;
  // window base field layout
  localparam int ACH_BASE_LSB = 22;
  localparam int ACH_SIZE_BITS = 6;
  localparam int ACH_UPPER_BITS = 4;
  localparam logic [9:0] ACH_BASE_STORE_RST = 10'h000;
  localparam logic [3:0] ACH_BASE_ATTR = 4'h8;
  localparam logic [17:0] ACH_BASE_ZERO_MID = 18'h00000;
  localparam logic [31:0] ACH_BASE_RST = 32'h00000008;
endpackage : ach_pkg

// File: ach_config_slice.sv
// aperture configuration header slice: class bytes, stub bytes and graphics window base
// assumes a dword configuration access port on the host clock and same-clock inputs
// for the size select register and the hub config word
`timescale 1ns/1ps

// What this block does
// - sub-category byte at 0Ah reads constant 00h, writes ignored
// - category byte at 0Bh reads constant 06h, writes ignored
// - latency timer byte at 0Dh reads zero, writes ignored
// - header layout byte at 0Eh reads zero, writes ignored
// - window base bits 31:28 are read/write storage, reset zero
// - window base bits 27:22 are storage or zero per size select
// - writable low bits choose 4, 8, 16, 32 MB up to 256 MB
// - all-ones write reads back zero in every held-zero bit
// - window accesses blocked while the hub config gate bit blocks
// - size select bit n gates window base bit 22+n
// - all-zero size select makes bits 27:22 zero, 256 MB
// - window base bits 21:4 read zero, minimum 4 MB
// - bit 3 reads one, bits 2:0 read zero
module ach_config_slice
  import ach_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_cfg_wr,
  input wire logic i_cfg_rd,
  input wire logic [7:0] i_cfg_addr,
  input wire logic [3:0] i_cfg_byte_en,
  input wire logic [31:0] i_cfg_wdata,
  input wire logic [ACH_SIZE_BITS-1:0] i_aperture_size_select,
  input wire logic i_hub_config_word_gate,
  input wire logic i_win_req,
  input wire logic [31:0] i_win_addr,
  output logic [31:0] o_cfg_rdata,
  output logic o_cfg_done,
  output logic o_win_hit,
  output logic o_win_blocked
);

  // decode on the dword address; low two bits are covered by byte enables
  wire logic [7:0] dw_addr = {i_cfg_addr[7:2], 2'b00};
  wire logic sel_class = (dw_addr == ACH_CLASS_DW_OFS);
  wire logic sel_timer = (dw_addr == ACH_TIMER_DW_OFS);
  wire logic sel_base = (dw_addr == ACH_BASE_DW_OFS);

  // stored window base bits 31:22; bits below are constants
  logic [9:0] base_reg;
  logic [9:0] base_next;
  logic [31:0] rdata_reg;
  logic [31:0] rdata_next;
  logic done_reg;
  logic hit_reg;
  logic blocked_reg;

  // gate mask: size select bit n enables base bit 22+n
  wire logic [9:0] store_mask = {{ACH_UPPER_BITS{1'b1}}, i_aperture_size_select};
  wire logic [9:0] base_eff = base_reg & store_mask;
  wire logic [31:0] base_view = {base_eff, ACH_BASE_ZERO_MID, ACH_BASE_ATTR};

  // byte-lane write merge; held-zero bits never capture ones
  wire logic base_wr = i_cfg_wr & sel_base;
  wire logic [9:0] lane_en = {{8{i_cfg_byte_en[3]}}, {2{i_cfg_byte_en[2]}}};
  wire logic [9:0] wr_bits = i_cfg_wdata[31:ACH_BASE_LSB] & store_mask;

  // base next value: upper bits plain storage, lower bits gated
  always_comb
  begin
    base_next = base_reg;
    if (base_wr)
    begin
      base_next = (base_reg & ~lane_en) | (wr_bits & lane_en);
    end
  end

  // read mux; the class and timer dwords hold only constants, so writes there are
  // accepted and dropped, other lanes of those dwords belong elsewhere and read zero
  always_comb
  begin
    rdata_next = 32'h00000000;
    if (sel_class)
    begin
      rdata_next = {ACH_CATEGORY_VAL, ACH_SUBCAT_VAL, 16'h0000};
    end
    else if (sel_timer)
    begin
      rdata_next = {8'h00, ACH_LAYOUT_VAL, ACH_LATENCY_VAL, 8'h00};
    end
    else if (sel_base)
    begin
      rdata_next = base_view;
    end
  end

  // window compare: upper bits always, gated bits only where writable
  wire logic [9:0] win_diff = (i_win_addr[31:ACH_BASE_LSB] ^ base_eff) & store_mask;
  wire logic win_match = (win_diff == 10'h000);
  wire logic win_open = i_hub_config_word_gate; // high lets the window through

  // configuration state and answers
  always_ff @(posedge i_clk)
  begin
    if (i_rst)
    begin
      base_reg <= ACH_BASE_STORE_RST;
      rdata_reg <= 32'h00000000;
      done_reg <= 1'b0;
    end
    else
    begin
      base_reg <= base_next;
      rdata_reg <= i_cfg_rd ? rdata_next : rdata_reg;
      done_reg <= i_cfg_rd | i_cfg_wr; // every access completes, no error
    end
  end

  // window hit and block flags, one cycle after the request
  always_ff @(posedge i_clk)
  begin
    if (i_rst)
    begin
      hit_reg <= 1'b0;
      blocked_reg <= 1'b0;
    end
    else
    begin
      hit_reg <= i_win_req & win_match & win_open;
      blocked_reg <= i_win_req & win_match & ~win_open;
    end
  end

  assign o_cfg_rdata = rdata_reg;
  assign o_cfg_done = done_reg;
  assign o_win_hit = hit_reg;
  assign o_win_blocked = blocked_reg;

  // checks on the register view and the window gate
  subcat_read_a: assert property (@(posedge i_clk) disable iff (i_rst)
    (i_cfg_rd && sel_class) |=> (o_cfg_rdata[23:16] == ACH_SUBCAT_VAL))
    else $error("sub-category byte not 00h");

  category_read_a: assert property (@(posedge i_clk) disable iff (i_rst)
    (i_cfg_rd && sel_class) |=> (o_cfg_rdata[31:24] == ACH_CATEGORY_VAL))
    else $error("category byte not 06h");

  latency_zero_a: assert property (@(posedge i_clk) disable iff (i_rst)
    (i_cfg_rd && sel_timer) |=> (o_cfg_rdata[15:8] == ACH_LATENCY_VAL))
    else $error("latency byte not zero");

  layout_zero_a: assert property (@(posedge i_clk) disable iff (i_rst)
    (i_cfg_rd && sel_timer) |=> (o_cfg_rdata[23:16] == 8'h00))
    else $error("header layout byte not zero");

  upper_base_a: assert property (@(posedge i_clk) disable iff (i_rst)
    (base_wr && i_cfg_byte_en[3]) |=> (base_reg[9:6] == $past(i_cfg_wdata[31:28])))
    else $error("upper base bits did not take the write");

  gated_bits_a: assert property (@(posedge i_clk) disable iff (i_rst)
    (i_cfg_rd && sel_base) |=> ((o_cfg_rdata[27:22] & ~$past(i_aperture_size_select)) == 6'h00))
    else $error("gated base bit read nonzero");

  const_bits_a: assert property (@(posedge i_clk) disable iff (i_rst)
    (i_cfg_rd && sel_base) |=> (o_cfg_rdata[21:0] == ACH_BASE_RST[21:0]))
    else $error("base low bits not 008h");

  ro_write_a: assert property (@(posedge i_clk) disable iff (i_rst)
    (i_cfg_wr && (sel_class || sel_timer)) |=> ($stable(base_reg) && o_cfg_done))
    else $error("read-only write disturbed state");

  window_block_a: assert property (@(posedge i_clk) disable iff (i_rst)
    (i_win_req && !i_hub_config_word_gate) |=> (!o_win_hit))
    else $error("window hit while gate blocks");

  // window flags, worked out from the stored bits and the address pins rather
  // than from the compare wires, so a broken compare cannot vouch for itself
  hit_open_a: assert property (@(posedge i_clk) disable iff (i_rst)
    (i_win_req && i_hub_config_word_gate && (i_win_addr[31:28] == base_reg[9:6])
      && (((i_win_addr[27:22] ^ base_reg[5:0]) & i_aperture_size_select) == 6'h00)) |=> o_win_hit)
    else $error("open window request not flagged as hit");

  blocked_flag_a: assert property (@(posedge i_clk) disable iff (i_rst)
    (i_win_req && !i_hub_config_word_gate && (i_win_addr[31:28] == base_reg[9:6])
      && (((i_win_addr[27:22] ^ base_reg[5:0]) & i_aperture_size_select) == 6'h00)) |=> o_win_blocked)
    else $error("gated window request not flagged as blocked");

  upper_miss_a: assert property (@(posedge i_clk) disable iff (i_rst)
    (i_win_req && (i_win_addr[31:28] != base_reg[9:6])) |=> (!o_win_hit && !o_win_blocked))
    else $error("request outside the window raised a flag");

  // register state and answer timing
  gated_store_a: assert property (@(posedge i_clk) disable iff (i_rst)
    (base_wr && i_cfg_byte_en[3] && i_cfg_byte_en[2]) |=> (base_reg[5:0] == ($past(i_cfg_wdata[27:22]) & $past(i_aperture_size_select))))
    else $error("gated base bits stored against size select");

  lane_keep_a: assert property (@(posedge i_clk) disable iff (i_rst)
    (base_wr && !i_cfg_byte_en[3] && !i_cfg_byte_en[2]) |=> $stable(base_reg))
    else $error("base changed by a write with its lanes off");

  reset_base_a: assert property (@(posedge i_clk) disable iff (i_rst)
    $fell(i_rst) |-> ((base_reg == ACH_BASE_STORE_RST) && (o_cfg_rdata == 32'h00000000)))
    else $error("base storage not zero after reset");

  done_pulse_a: assert property (@(posedge i_clk) disable iff (i_rst)
    (i_cfg_rd || i_cfg_wr) |=> o_cfg_done)
    else $error("access did not complete");

  write_quiet_a: assert property (@(posedge i_clk) disable iff (i_rst)
    (i_cfg_wr && !i_cfg_rd) |=> $stable(o_cfg_rdata))
    else $error("read data changed on a write");

  upper_read_a: assert property (@(posedge i_clk) disable iff (i_rst)
    (i_cfg_rd && sel_base) |=> (o_cfg_rdata[31:28] == $past(base_reg[9:6])))
    else $error("upper base bits read back wrong");

  size_default_a: assert property (@(posedge i_clk) disable iff (i_rst)
    (i_cfg_rd && sel_base && (i_aperture_size_select == 6'h00)) |=> (o_cfg_rdata[27:22] == 6'h00))
    else $error("gated bits nonzero with size select all zero");

  base_attr_a: assert property (@(posedge i_clk) disable iff (i_rst)
    (i_cfg_rd && sel_base) |=> (o_cfg_rdata[3:0] == ACH_BASE_ATTR))
    else $error("base attribute bits not 8h");

endmodule : ach_config_slice

// File: ach_config_slice_bench.sv
// testbench for the aperture configuration header slice
// assumes the dword config port with a one-cycle done pulse and registered window flags
`timescale 1ns/1ps
module ach_config_slice_bench
  import ach_pkg::*;
;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic cfg_wr = 1'b0;
  logic cfg_rd = 1'b0;
  logic win_req = 1'b0;
  logic gate = 1'b0;
  logic [7:0] addr = 8'h00;
  logic [3:0] be = 4'h0;
  logic [31:0] wdata = 32'h0;
  logic [31:0] win_addr = 32'h0;
  logic [5:0] size = 6'h00;
  logic [31:0] rdata;
  logic done, hit, blocked;
  int failures = 0;
  int n_compared = 0;
  int cycles = 0;
  logic [5:0] sizes [6] = '{6'h3F, 6'h3E, 6'h3C, 6'h38, 6'h15, 6'h00};

  ach_config_slice u_ach_config_slice (.i_clk(clk), .i_rst(rst), .i_cfg_wr(cfg_wr), .i_cfg_rd(cfg_rd),
    .i_cfg_addr(addr), .i_cfg_byte_en(be), .i_cfg_wdata(wdata), .i_aperture_size_select(size),
    .i_hub_config_word_gate(gate), .i_win_req(win_req), .i_win_addr(win_addr), .o_cfg_rdata(rdata),
    .o_cfg_done(done), .o_win_hit(hit), .o_win_blocked(blocked));

  // free-running 100 MHz clock
  initial
  begin
    forever #5 clk = ~clk;
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      failures++;
      $display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  // one access; done is looked at in the single cycle it stands
  task automatic cfg(input logic w, input logic [7:0] a, input logic [3:0] b, input logic [31:0] d);
    @(posedge clk);
    cfg_wr <= w;
    cfg_rd <= !w;
    addr <= a;
    be <= b;
    wdata <= d;
    @(posedge clk);
    cfg_wr <= 1'b0;
    cfg_rd <= 1'b0;
    #1;
    check({31'h0, done}, 32'h1);
  endtask : cfg

  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    cfg(1'b0, a, 4'h0, 32'h0);
    check(rdata, exp);
  endtask : rd

  // window request; flags answer one cycle later
  task automatic win(input logic [31:0] a, input logic [1:0] exp);
    @(posedge clk);
    win_req <= 1'b1;
    win_addr <= a;
    @(posedge clk);
    win_req <= 1'b0;
    #1;
    check({30'h0, hit, blocked}, {30'h0, exp});
  endtask : win

  task automatic wrap_up;
    $display("compared %0d mismatches %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : wrap_up

  // hang guard, the tests need about 70 cycles
  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 3000)
    begin
      failures++;
      wrap_up();
    end
  end

  initial
  begin
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    rd(8'h10, 32'h00000008);
    rd(8'h08, 32'h06000000);
    rd(8'h0C, 32'h00000000);
    cfg(1'b1, 8'h08, 4'hF, 32'hFFFFFFFF);
    cfg(1'b1, 8'h0C, 4'hF, 32'hFFFFFFFF);
    rd(8'h08, 32'h06000000);
    rd(8'h0C, 32'h00000000);
    $display("test class and stub bytes done");
    // each size: all-ones write reads back the upper bits, the enabled gated bits and bit 3
    foreach (sizes[i])
    begin
      @(posedge clk);
      size <= sizes[i];
      cfg(1'b1, 8'h10, 4'hF, 32'hFFFFFFFF);
      rd(8'h10, {4'hF, sizes[i], 22'h8});
    end
    $display("test size sweep done");
    @(posedge clk);
    size <= 6'h3F;
    cfg(1'b1, 8'h10, 4'hF, 32'hFFFFFFFF);
    cfg(1'b1, 8'h10, 4'h0, 32'h0);
    rd(8'h10, 32'hFFC00008);
    cfg(1'b1, 8'h10, 4'h8, 32'h0);
    rd(8'h10, 32'h00C00008);
    $display("test byte enables done");
    @(posedge clk);
    size <= 6'h3C;
    gate <= 1'b1;
    cfg(1'b1, 8'h10, 4'hF, 32'h5A000000);
    rd(8'h10, 32'h5A000008);
    win(32'h5A123456, 2'b10);
    win(32'h5A400000, 2'b10);
    win(32'h6A000000, 2'b00);
    @(posedge clk);
    gate <= 1'b0;
    win(32'h5A123456, 2'b01);
    $display("test window gate done");
    wrap_up();
  end
endmodule : ach_config_slice_bench
